// ---- design/dcr_unit.sv ----
module dcr_unit #(
  parameter int DIV_W = 8
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Power management requests
  input  wire logic        stop_main_osc,
  input  wire logic        stop_slow_osc,
  // Oscillator and reset pins
  input  wire logic        slow_osc_in,
  input  wire logic        power_on_det,
  input  wire logic        ext_rst_n,
  // Clock and reset outputs
  output logic             main_osc_en,
  output logic             slow_osc_en,
  output logic             main_clk_good,
  output logic             slow_clk_good,
  output logic             slow_clk,
  output logic             prescaler_run,
  output logic             sys_rst_n
);

  // Bus state
  logic             ack;
  logic             next_ack;
  logic [31:0]      next_readdata;
  logic             sclk_sel;
  logic             next_sclk_sel;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W-1:0] next_divisor;
  logic             por_flag;
  logic             next_por_flag;

  // Main start-up and reset state
  logic [13:0]      main_cnt;
  logic [13:0]      next_main_cnt;
  logic             main_step;
  logic             next_main_step;
  logic             next_main_good;
  dcr_pkg::dcr_por_e por_st;
  dcr_pkg::dcr_por_e next_por_st;
  logic             next_sys_rst_n;

  // Slow start-up state
  logic             slow_s1;
  logic             slow_s2;
  logic             slow_prev;
  logic [5:0]       slow_cnt;
  logic [5:0]       next_slow_cnt;
  logic             next_slow_good;

  // Slow clock generation
  logic [DIV_W-1:0] pre_cnt;
  logic [DIV_W-1:0] next_pre_cnt;
  logic             pre_clk;
  logic             next_pre_clk;
  logic             osc_active;
  logic             next_osc_active;
  logic             next_slow_clk;

  // Bus and edge strobes
  logic             wr_en;
  logic             slow_rise;

  // One wait state: answer comes the cycle after the request is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en           = avs_write & ack;
  assign slow_rise       = slow_s2 & ~slow_prev;

  // Oscillator enables follow the halt requests directly
  // Kept combinational so a halt stops the oscillator at once
  assign main_osc_en = ~stop_main_osc;
  assign slow_osc_en = ~stop_slow_osc;

  // Bus decode and register writes
  always_comb begin
    next_ack      = (avs_read | avs_write) & ~ack;
    next_readdata = 32'h0000_0000;
    next_sclk_sel = sclk_sel;
    next_divisor  = divisor;
    next_por_flag = por_flag;
    // Read data is staged while the request waits, so it stands
    // at the edge where waitrequest is low
    if (avs_read && !ack) begin
      case (avs_address)
        dcr_pkg::OFS_CTRL: begin
          next_readdata[dcr_pkg::CTRL_POR_BIT]  = por_flag;
          next_readdata[dcr_pkg::CTRL_SCLK_BIT] = sclk_sel;
        end
        dcr_pkg::OFS_PRESC: begin
          next_readdata[DIV_W-1:0] = divisor;
        end
        dcr_pkg::OFS_STATUS: begin
          next_readdata[dcr_pkg::STAT_MAIN_BIT] = main_clk_good;
          next_readdata[dcr_pkg::STAT_SLOW_BIT] = slow_clk_good;
          next_readdata[dcr_pkg::STAT_OSCS_BIT] = osc_active;
          next_readdata[dcr_pkg::STAT_RST_BIT]  = sys_rst_n;
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr_en && avs_address == dcr_pkg::OFS_CTRL) begin
      next_sclk_sel = avs_writedata[dcr_pkg::CTRL_SCLK_BIT];
      // Only a zero has effect; a one is ignored
      if (!avs_writedata[dcr_pkg::CTRL_POR_BIT]) begin
        next_por_flag = 1'b0;
      end
    end
    // Any divisor is accepted; keeping the rate legal is up to software
    if (wr_en && avs_address == dcr_pkg::OFS_PRESC) begin
      next_divisor = avs_writedata[DIV_W-1:0];
    end
    // Hardware set wins over a clear in the same cycle
    if (power_on_det) begin
      next_por_flag = 1'b1;
    end
  end

  // Bus registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      sclk_sel     <= dcr_pkg::SCLK_RST;
      divisor      <= DIV_W'(dcr_pkg::PRESC_RST);
      por_flag     <= dcr_pkg::POR_RST;
    end else begin
      ack          <= next_ack;
      avs_readdata <= next_readdata;
      sclk_sel     <= next_sclk_sel;
      divisor      <= next_divisor;
      por_flag     <= next_por_flag;
    end
  end

  // Main start-up counter, shared with the power-on supervisor.
  // The preload gives 16383 steps; stepping every other cycle
  // stretches that to 32766 cycles, just short of the 32768-cycle delay.
  always_comb begin
    next_main_cnt  = main_cnt;
    next_main_step = 1'b0;
    next_por_st    = por_st;
    if (stop_main_osc || power_on_det) begin
      next_main_cnt = dcr_pkg::MAIN_PRELOAD;
    end else if (main_cnt != 14'h0000) begin
      next_main_step = ~main_step;
      if (main_step) begin
        next_main_cnt = main_cnt - 14'h0001;
      end
    end
    // Supervisor leaves hold only once the count has run out
    case (por_st)
      dcr_pkg::DCR_POR_HOLD: begin
        if (!power_on_det && !stop_main_osc && main_cnt == 14'h0000) begin
          next_por_st = dcr_pkg::DCR_POR_RUN;
        end
      end
      dcr_pkg::DCR_POR_RUN: begin
        if (power_on_det) begin
          next_por_st = dcr_pkg::DCR_POR_HOLD;
        end
      end
      default: begin
        // An unknown code falls back to holding reset
        next_por_st = dcr_pkg::DCR_POR_HOLD;
      end
    endcase
    // Good only while running and counted out; drops on halt
    next_main_good = ~stop_main_osc & ~power_on_det
                   & (next_main_cnt == 14'h0000);
    // Pin low keeps reset asserted whatever the countdown says
    next_sys_rst_n = ext_rst_n
                   & (next_por_st == dcr_pkg::DCR_POR_RUN);
  end

  // Main counter, supervisor and reset output registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      main_cnt      <= dcr_pkg::MAIN_PRELOAD;
      main_step     <= 1'b0;
      por_st        <= dcr_pkg::DCR_POR_HOLD;
      main_clk_good <= 1'b0;
      sys_rst_n     <= 1'b0;
    end else begin
      main_cnt      <= next_main_cnt;
      main_step     <= next_main_step;
      por_st        <= next_por_st;
      main_clk_good <= next_main_good;
      sys_rst_n     <= next_sys_rst_n;
    end
  end

  // Slow oscillator synchroniser; only the second stage is used
  // The third flop only delays the level for edge detection
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      slow_s1   <= 1'b0;
      slow_s2   <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      slow_s1   <= slow_osc_in;
      slow_s2   <= slow_s1;
      slow_prev <= slow_s2;
    end
  end

  // Slow start-up counter steps on each oscillator rising edge
  // A stopped oscillator rests low, so nothing counts while halted
  always_comb begin
    next_slow_cnt = slow_cnt;
    if (stop_slow_osc) begin
      next_slow_cnt = dcr_pkg::SLOW_PRELOAD;
    end else if (slow_rise && slow_cnt != 6'h00) begin
      next_slow_cnt = slow_cnt - 6'h01;
    end
    next_slow_good = ~stop_slow_osc & (next_slow_cnt == 6'h00);
  end

  // Slow counter and stable flag registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      slow_cnt      <= dcr_pkg::SLOW_PRELOAD;
      slow_clk_good <= 1'b0;
    end else begin
      slow_cnt      <= next_slow_cnt;
      slow_clk_good <= next_slow_good;
    end
  end

  // Prescaler and source mux. The oscillator is taken only once
  // its start-up count proves it toggles; if it is halted, the mux
  // falls back to the prescaler. Switching is not glitch-free.
  always_comb begin
    next_osc_active = sclk_sel & next_slow_good;
    next_pre_cnt    = pre_cnt;
    next_pre_clk    = pre_clk;
    if (osc_active) begin
      // Parked while the oscillator drives the slow clock
      next_pre_cnt = '0;
    end else if (pre_cnt == divisor) begin
      // Divisor stage wraps after divisor+1 cycles; the toggle flop
      // is the fixed divide-by-two, so the period is (divisor+1)*2
      next_pre_cnt = '0;
      next_pre_clk = ~pre_clk;
    end else begin
      next_pre_cnt = pre_cnt + DIV_W'(1);
    end
    // Oscillator level is glitch-free; prescaler output is a flop
    next_slow_clk = osc_active ? slow_s2 : next_pre_clk;
  end

  // Source select and prescaler registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      osc_active <= 1'b0;
      pre_cnt    <= '0;
      pre_clk    <= 1'b0;
      slow_clk   <= 1'b0;
    end else begin
      osc_active <= next_osc_active;
      pre_cnt    <= next_pre_cnt;
      pre_clk    <= next_pre_clk;
      slow_clk   <= next_slow_clk;
    end
  end

  // Prescaler runs whenever the oscillator path is not in use
  // Its low level tells the power manager the main clock may stop
  assign prescaler_run = ~osc_active;

endmodule : dcr_unit

// ---- design/dcr_pkg.sv ----
package dcr_pkg;

  // Register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_PRESC  = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Control register fields
  localparam int CTRL_POR_BIT  = 6;
  localparam int CTRL_SCLK_BIT = 5;

  // Status register fields
  localparam int STAT_MAIN_BIT = 0;
  localparam int STAT_SLOW_BIT = 1;
  localparam int STAT_OSCS_BIT = 2;
  localparam int STAT_RST_BIT  = 3;

  // Values after reset
  localparam logic       SCLK_RST  = 1'b0;
  localparam logic [7:0] PRESC_RST = 8'hFF;
  localparam logic       POR_RST   = 1'b1;

  // Start-up counters
  localparam int         MAIN_W       = 14;
  localparam int         SLOW_W       = 6;
  localparam logic [13:0] MAIN_PRELOAD = 14'h3FFF;
  localparam logic [5:0]  SLOW_PRELOAD = 6'h3F;

  // Main start-up delay in cycles; counter steps every other cycle
  localparam int MAIN_DELAY_CYC = 32768;
  localparam int MAIN_STEP_CYC  = MAIN_DELAY_CYC / (int'(MAIN_PRELOAD) + 1);

  // Reset supervisor states
  typedef enum logic [0:0] {
    DCR_POR_HOLD = 1'b0,
    DCR_POR_RUN  = 1'b1
  } dcr_por_e;

endpackage : dcr_pkg

// ---- verification/dcr_monitor.sv ----
module dcr_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Requests and pins
  input wire logic stop_main_osc,
  input wire logic stop_slow_osc,
  input wire logic power_on_det,
  input wire logic ext_rst_n,
  // Outputs watched
  input wire logic main_osc_en,
  input wire logic slow_osc_en,
  input wire logic main_clk_good,
  input wire logic slow_clk_good,
  input wire logic prescaler_run,
  input wire logic sys_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // A restart must leave the good flag low for a long stretch, not one cycle
  sequence main_restart_s;
    $fell(stop_main_osc) ##1 !main_clk_good [*8];
  endsequence
  main_en_a: assert property (main_osc_en == !stop_main_osc) else $error("main enable wrong");
  slow_en_a: assert property (slow_osc_en == !stop_slow_osc) else $error("slow enable wrong");
  main_drop_a: assert property (stop_main_osc |=> !main_clk_good) else $error("main good kept");
  slow_drop_a: assert property (stop_slow_osc |=> !slow_clk_good) else $error("slow good kept");
  ext_rst_a: assert property (!ext_rst_n |=> !sys_rst_n) else $error("pin reset ignored");
  por_rst_a: assert property (power_on_det |=> !sys_rst_n) else $error("power-on ignored");
  restart_low_a: assert property ($fell(stop_main_osc) |-> main_restart_s) else $error("early good");
  good_hold_a: assert property ($fell(main_clk_good) |-> !main_clk_good [*8]) else $error("glitch");
  src_good_a: assert property (!prescaler_run |-> slow_clk_good) else $error("bad switch");
  rst_good_a: assert property ($rose(sys_rst_n) |-> main_clk_good) else $error("early release");
endmodule : dcr_monitor

bind dcr_unit dcr_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .stop_main_osc(stop_main_osc),
  .stop_slow_osc(stop_slow_osc), .power_on_det(power_on_det), .ext_rst_n(ext_rst_n),
  .main_osc_en(main_osc_en), .slow_osc_en(slow_osc_en), .main_clk_good(main_clk_good),
  .slow_clk_good(slow_clk_good), .prescaler_run(prescaler_run), .sys_rst_n(sys_rst_n));

// ---- verification/dcr_pm_model.sv ----
module dcr_pm_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Commands from the bench
  input  wire logic halt_main,
  input  wire logic halt_slow,
  // Oscillator side
  input  wire logic slow_osc_en,
  output logic      stop_main_osc,
  output logic      stop_slow_osc,
  output logic      slow_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  // Halt requests are registered levels; the stopped oscillator rests low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stop_main_osc <= 1'b0;
      stop_slow_osc <= 1'b0;
      ph            <= 3'h0;
      slow_osc_in   <= 1'b0;
    end else begin
      stop_main_osc <= halt_main;
      stop_slow_osc <= halt_slow;
      ph <= slow_osc_en ? ph + 3'h1 : 3'h0;
      if (!slow_osc_en)
        slow_osc_in <= 1'b0;
      else if (ph == 3'h7)
        slow_osc_in <= !slow_osc_in; // Half period of 8 cycles
    end
  end
endmodule : dcr_pm_model

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] POR = 32'h1 << dcr_pkg::CTRL_POR_BIT;
  localparam logic [31:0] SCK = 32'h1 << dcr_pkg::CTRL_SCLK_BIT;
  localparam logic [31:0] ST = (32'h1 << dcr_pkg::STAT_MAIN_BIT) | (32'h1 << dcr_pkg::STAT_RST_BIT);
  localparam logic [31:0] SG = 32'h1 << dcr_pkg::STAT_SLOW_BIT;
  logic        clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        power_on_det = 1'b0, ext_rst_n = 1'b1, halt_main = 1'b0, halt_slow = 1'b0;
  logic        avs_waitrequest, stop_main_osc, stop_slow_osc, slow_osc_in, main_osc_en;
  logic        slow_osc_en, main_clk_good, slow_clk_good, slow_clk, prescaler_run, sys_rst_n;
  int          n_fail = 0, num_checks = 0, n, m;
  // Free-running 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  dcr_unit dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_main_osc(stop_main_osc),
    .stop_slow_osc(stop_slow_osc), .slow_osc_in(slow_osc_in), .power_on_det(power_on_det),
    .ext_rst_n(ext_rst_n), .main_osc_en(main_osc_en), .slow_osc_en(slow_osc_en),
    .main_clk_good(main_clk_good), .slow_clk_good(slow_clk_good), .slow_clk(slow_clk),
    .prescaler_run(prescaler_run), .sys_rst_n(sys_rst_n));
  dcr_pm_model u_pm (.clk_sys(clk_sys), .nrst(nrst), .halt_main(halt_main),
    .halt_slow(halt_slow), .slow_osc_en(slow_osc_en), .stop_main_osc(stop_main_osc),
    .stop_slow_osc(stop_slow_osc), .slow_osc_in(slow_osc_in));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Counts cycles until a settled output reaches a level; a hang ends the run
  task automatic wait_v(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    @(negedge clk_sys);
    while (s !== v) begin
      @(negedge clk_sys);
      c++;
      if (c > lim) begin
        n_fail++;
        end_sim();
      end
    end
  endtask : wait_v
  // One bus transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int c;
    c = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Waitrequest and read data are judged at the same rising edge
    do begin
      @(posedge clk_sys);
      c++;
      if (c > 20) begin
        n_fail++;
        end_sim();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    // Power-up countdown, then reset values and an unmapped hole
    wait_v(sys_rst_n, 1'b1, 34000, n);
    chk(32'(n >= 32766 && n <= 32772), 32'h1);
    rd(dcr_pkg::OFS_CTRL, POR);
    rd(dcr_pkg::OFS_PRESC, 32'hFF);
    rd(4'hC, 32'h0);
    // Pin reset holds and releases without a new countdown
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(sys_rst_n, 1'b0);
    ext_rst_n <= 1'b1;
    wait_v(sys_rst_n, 1'b1, 4, n);
    chk(n, 32'h1);
    // Flag clears by software, never sets
    wr(dcr_pkg::OFS_CTRL, 32'h0);
    rd(dcr_pkg::OFS_CTRL, 32'h0);
    wr(dcr_pkg::OFS_CTRL, POR);
    rd(dcr_pkg::OFS_CTRL, 32'h0);
    // Prescaled slow clock at the reset divisor, the one legal at 50 MHz
    // Start from a low level so both halves are measured whole
    wait_v(slow_clk, 1'b0, 600, n);
    wait_v(slow_clk, 1'b1, 600, n);
    wait_v(slow_clk, 1'b0, 600, n);
    wait_v(slow_clk, 1'b1, 600, m);
    // Each wait spends one uncounted cycle before it counts
    chk(n + m + 2, 32'd512);
    // Main restart takes the full start-up delay
    halt_main <= 1'b1;
    wait_v(main_clk_good, 1'b0, 4, n);
    chk(main_osc_en, 1'b0);
    halt_main <= 1'b0;
    wait_v(main_clk_good, 1'b1, 34000, n);
    chk(32'(n >= 32766 && n <= 32772), 32'h1);
    // Slow restart counts 63 oscillator edges
    halt_slow <= 1'b1;
    wait_v(slow_clk_good, 1'b0, 4, n);
    chk(slow_osc_en, 1'b0);
    wr(dcr_pkg::OFS_CTRL, SCK);
    repeat (4) @(posedge clk_sys);
    chk(prescaler_run, 1'b1);
    rd(dcr_pkg::OFS_STATUS, ST);
    halt_slow <= 1'b0;
    wait_v(slow_clk_good, 1'b1, 1200, n);
    chk(32'(n >= 995 && n <= 1012), 32'h1);
    wait_v(prescaler_run, 1'b0, 4, n);
    rd(dcr_pkg::OFS_STATUS, ST | SG | (32'h1 << dcr_pkg::STAT_OSCS_BIT));
    wait_v(slow_clk, 1'b0, 40, n);
    wait_v(slow_clk, 1'b1, 40, n);
    wait_v(slow_clk, 1'b0, 40, n);
    chk(32'(n >= 6 && n <= 9), 32'h1);
    // Power-on event resets the system and raises the flag
    @(posedge clk_sys);
    power_on_det <= 1'b1;
    @(posedge clk_sys);
    power_on_det <= 1'b0;
    wait_v(sys_rst_n, 1'b0, 4, n);
    rd(dcr_pkg::OFS_CTRL, POR | SCK);
    end_sim();
  end
endmodule : tb_top
